// [core/mailbox_params.svh]
/*
 Constants of the shared-memory mailbox: map offsets, word indices and masks.
 Assumes a 16-bit word memory of 8 KiB, byte addressed, bit 0 of an address ignored.
*/
`ifndef MAILBOX_PARAMS_SVH
`define MAILBOX_PARAMS_SVH

`define AW 13
`define DW 16
`define RAM_WORDS 4096
`define NREG 26

// Data areas
`define OFS_TIMERS 13'h0000
`define OFS_PROC_IMG 13'h0300
`define OFS_FLAG_IN 13'h0500
`define OFS_FLAG_OUT 13'h0600
`define OFS_FLAG_OUT_END 13'h0700
`define OFS_BLK_RD 13'h0700
`define OFS_BLK_WR 13'h0900
`define OFS_BLK_WR_END 13'h0b00
`define OFS_COMM 13'h1000
`define OFS_CARD_OUT 13'h1100
`define OFS_FAST 13'h1300
`define OFS_FAST_END 13'h1f00

// Communication words
`define OFS_IN_REQ 13'h1010
`define OFS_IN_ACK 13'h1012
`define OFS_OUT_REQ 13'h1014
`define OFS_OUT_ACK 13'h1016
`define OFS_RD_NUM 13'h1020
`define OFS_RD_OFF 13'h1022
`define OFS_RD_CNT 13'h1024
`define OFS_RD_REQ 13'h1026
`define OFS_RD_ACK 13'h1028
`define OFS_WR_NUM 13'h102a
`define OFS_WR_OFF 13'h102c
`define OFS_WR_CNT 13'h102e
`define OFS_WR_REQ 13'h1030
`define OFS_WR_ACK 13'h1032
`define OFS_CO_RDY 13'h1034
`define OFS_CO_READ 13'h1036
`define OFS_CI_PRES 13'h1038
`define OFS_CI_TAKEN 13'h103a
`define OFS_STATUS 13'h1040
`define OFS_STOP_ERR 13'h1042
`define OFS_SPECIAL 13'h1044
`define OFS_ERR_RST 13'h1046
`define OFS_FB_ERR 13'h1048
`define OFS_HW_STAT 13'h104a
`define OFS_SCAN 13'h1060

// Register indices
`define RI_IN_REQ 5'h00
`define RI_IN_ACK 5'h01
`define RI_OUT_REQ 5'h02
`define RI_OUT_ACK 5'h03
`define RI_RD_NUM 5'h04
`define RI_RD_OFF 5'h05
`define RI_RD_CNT 5'h06
`define RI_RD_REQ 5'h07
`define RI_RD_ACK 5'h08
`define RI_WR_NUM 5'h09
`define RI_WR_OFF 5'h0a
`define RI_WR_CNT 5'h0b
`define RI_WR_REQ 5'h0c
`define RI_WR_ACK 5'h0d
`define RI_CO_RDY 5'h0e
`define RI_CO_READ 5'h0f
`define RI_CI_PRES 5'h10
`define RI_CI_TAKEN 5'h11
`define RI_STATUS 5'h12
`define RI_STOP_ERR 5'h13
`define RI_SPECIAL 5'h14
`define RI_ERR_RST 5'h15
`define RI_FB_ERR 5'h16
`define RI_HW_STAT 5'h17
`define RI_SCAN 5'h18
`define RI_NONE 5'h19

// Bit masks and the block read channel number
`define FLAG_MASK 16'h0001
`define BLK_MASK 16'h0003
`define ERR_FLAG 16'h8000
`define CHAN_BLK_RD 2'h2

`endif

// [core/mailbox_pkg.sv]
/*
 Types shared by both ends of the mailbox, and the address decoding used by the device end.
 Assumes mailbox_params.svh is on the include path.
*/
`include "mailbox_params.svh"

package mailbox_pkg;
    typedef logic [`DW-1:0] word_t;
    typedef logic [`AW-1:0] addr_t;
    typedef logic [4:0] reg_idx_t;

    typedef enum logic [2:0] {
        CH_IDLE = 3'h1,
        CH_BUSY = 3'h2,
        CH_ACK = 3'h4
    } chan_state_t;

    typedef enum logic [6:0] {
        H_IDLE = 7'h01,
        H_PARAM = 7'h02,
        H_REQ = 7'h04,
        H_POLL = 7'h08,
        H_HOLD = 7'h10,
        H_CLR = 7'h20,
        H_POLLZ = 7'h40
    } host_state_t;

    typedef struct packed {
        word_t [`NREG-1:0] regs;
        chan_state_t [3:0] st;
        logic [3:0][1:0] kind;
        word_t cpu_rdata;
    } dev_state_t;

    typedef struct packed {
        host_state_t st;
        logic [1:0] chan;
        logic [1:0] kind;
        word_t [2:0] prm;
        logic [1:0] p;
        logic issued;
        logic [1:0] pend;
        word_t ack;
        logic done;
    } host_state_s_t;

    function automatic reg_idx_t reg_index(input addr_t a);
        case ({a[`AW-1:1], 1'b0})
            `OFS_IN_REQ: reg_index = `RI_IN_REQ;
            `OFS_IN_ACK: reg_index = `RI_IN_ACK;
            `OFS_OUT_REQ: reg_index = `RI_OUT_REQ;
            `OFS_OUT_ACK: reg_index = `RI_OUT_ACK;
            `OFS_RD_NUM: reg_index = `RI_RD_NUM;
            `OFS_RD_OFF: reg_index = `RI_RD_OFF;
            `OFS_RD_CNT: reg_index = `RI_RD_CNT;
            `OFS_RD_REQ: reg_index = `RI_RD_REQ;
            `OFS_RD_ACK: reg_index = `RI_RD_ACK;
            `OFS_WR_NUM: reg_index = `RI_WR_NUM;
            `OFS_WR_OFF: reg_index = `RI_WR_OFF;
            `OFS_WR_CNT: reg_index = `RI_WR_CNT;
            `OFS_WR_REQ: reg_index = `RI_WR_REQ;
            `OFS_WR_ACK: reg_index = `RI_WR_ACK;
            `OFS_CO_RDY: reg_index = `RI_CO_RDY;
            `OFS_CO_READ: reg_index = `RI_CO_READ;
            `OFS_CI_PRES: reg_index = `RI_CI_PRES;
            `OFS_CI_TAKEN: reg_index = `RI_CI_TAKEN;
            `OFS_STATUS: reg_index = `RI_STATUS;
            `OFS_STOP_ERR: reg_index = `RI_STOP_ERR;
            `OFS_SPECIAL: reg_index = `RI_SPECIAL;
            `OFS_ERR_RST: reg_index = `RI_ERR_RST;
            `OFS_FB_ERR: reg_index = `RI_FB_ERR;
            `OFS_HW_STAT: reg_index = `RI_HW_STAT;
            `OFS_SCAN: reg_index = `RI_SCAN;
            default: reg_index = `RI_NONE;
        endcase
    endfunction

    function automatic logic host_owns(input reg_idx_t i);
        case (i)
            `RI_IN_REQ, `RI_OUT_REQ, `RI_RD_NUM, `RI_RD_OFF, `RI_RD_CNT, `RI_RD_REQ,
            `RI_WR_NUM, `RI_WR_OFF, `RI_WR_CNT, `RI_WR_REQ, `RI_CO_READ, `RI_CI_PRES,
            `RI_SPECIAL, `RI_ERR_RST: host_owns = 1'b1;
            default: host_owns = 1'b0;
        endcase
    endfunction
endpackage

// [core/mailbox_if.sv]
/*
 Word access link between the host end and the device end of the mailbox.
 Assumes both ends share clk_in; the testbench instantiates and joins them.
*/
`timescale 1ns/10ps

interface mailbox_if;
    logic req_valid;
    logic req_ready;
    logic req_we;
    logic [12:0] req_addr;
    logic [15:0] req_wdata;
    logic rsp_valid;
    logic rsp_ready;
    logic [15:0] rsp_data;

    modport host (
        output req_valid, req_we, req_addr, req_wdata, rsp_ready,
        input req_ready, rsp_valid, rsp_data
    );
    modport device (
        input req_valid, req_we, req_addr, req_wdata, rsp_ready,
        output req_ready, rsp_valid, rsp_data
    );
endinterface

// [core/mailbox_buffer.sv]
/*
 Two-entry valid/ready buffer on the response path of the device end.
 Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/10ps

module mailbox_buffer #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } buf_state_t;

    buf_state_t q, d;
    logic push, pop;

    assign in_ready_out = (q.cnt != 2'h2);
    assign out_valid_out = (q.cnt != 2'h0);
    assign out_data_out = q.mem[q.rp];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data_in;
            d.wp = ~q.wp;
        end
        if (pop) begin
            d.rp = ~q.rp;
        end
        case ({push, pop})
            2'b10: d.cnt = q.cnt + 2'h1;
            2'b01: d.cnt = q.cnt - 2'h1;
            default: d.cnt = q.cnt;
        endcase
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// [core/mailbox_device.sv]
/*
 Device end of the shared-memory mailbox: memory, communication words, handshakes.
 Assumes a host end on the mailbox_if link and a control CPU on the user ports.
*/
`timescale 1ns/10ps

module mailbox_device
    import mailbox_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Link to host end
    mailbox_if.device link,
    // Control CPU memory port, word indexed
    input wire logic cpu_we_in,
    input wire logic [11:0] cpu_addr_in,
    input wire logic [15:0] cpu_wdata_in,
    output logic [15:0] cpu_rdata_out,
    // Transfer channels: 0 in flags, 1 out flags, 2 block read, 3 block write
    output logic [3:0] chan_req_out,
    output logic [1:0] rd_kind_out,
    output logic [1:0] wr_kind_out,
    input wire logic [3:0] chan_done_in,
    input wire logic rd_err_in,
    input wire logic [15:0] rd_err_code_in,
    // Block parameters
    output logic [15:0] rd_num_out,
    output logic [15:0] rd_off_out,
    output logic [15:0] rd_cnt_out,
    output logic [15:0] wr_num_out,
    output logic [15:0] wr_off_out,
    output logic [15:0] wr_cnt_out,
    // Card coupling
    input wire logic card_out_ready_in,
    input wire logic card_in_taken_in,
    output logic card_out_reading_out,
    output logic card_in_present_out,
    // Status and control words
    input wire logic [15:0] status_in,
    input wire logic [15:0] stop_err_in,
    input wire logic [15:0] hw_status_in,
    input wire logic [15:0] scan_time_in,
    output logic [15:0] special_out,
    output logic err_reset_req_out,
    input wire logic err_reset_done_in
);
    localparam reg_idx_t [3:0] REQ_IX = {`RI_WR_REQ, `RI_RD_REQ, `RI_OUT_REQ, `RI_IN_REQ};
    localparam reg_idx_t [3:0] ACK_IX = {`RI_WR_ACK, `RI_RD_ACK, `RI_OUT_ACK, `RI_IN_ACK};
    localparam word_t [3:0] MASK = {`BLK_MASK, `BLK_MASK, `FLAG_MASK, `FLAG_MASK};

    dev_state_t q, d;
    word_t ram [`RAM_WORDS];
    logic acc, hwr, ram_wr, in_comm, buf_ready;
    reg_idx_t idx;
    word_t rsp_word, req_bits;

    // Host may write only its data areas; image areas are read-only to it
    function automatic logic host_ram_area(input addr_t a);
        host_ram_area = (a >= `OFS_FLAG_OUT && a < `OFS_FLAG_OUT_END)
            || (a >= `OFS_BLK_WR && a < `OFS_BLK_WR_END)
            || (a >= `OFS_FAST && a < `OFS_FAST_END);
    endfunction

    assign acc = link.req_valid && buf_ready;
    assign link.req_ready = buf_ready;
    assign idx = reg_index(link.req_addr);
    assign in_comm = (link.req_addr >= `OFS_COMM) && (link.req_addr < `OFS_CARD_OUT);
    assign hwr = acc && link.req_we && host_owns(idx);
    assign ram_wr = acc && link.req_we && host_ram_area(link.req_addr);

    // Reads see the state before this cycle's update
    always_comb begin
        if (link.req_we) begin
            rsp_word = '0;
        end else if (idx != `RI_NONE) begin
            rsp_word = q.regs[idx];
        end else if (in_comm) begin
            rsp_word = '0;
        end else begin
            rsp_word = ram[link.req_addr[`AW-1:1]];
        end
    end

    mailbox_buffer #(.WIDTH(`DW)) rsp_buf (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .in_valid_in(acc),
        .in_ready_out(buf_ready),
        .in_data_in(rsp_word),
        .out_valid_out(link.rsp_valid),
        .out_ready_in(link.rsp_ready),
        .out_data_out(link.rsp_data)
    );

    always_comb begin
        d = q;
        req_bits = '0;
        d.cpu_rdata = ram[cpu_addr_in];
        d.regs[`RI_CO_RDY] = {15'h0000, card_out_ready_in};
        d.regs[`RI_CI_TAKEN] = {15'h0000, card_in_taken_in};
        d.regs[`RI_STATUS] = status_in;
        d.regs[`RI_STOP_ERR] = stop_err_in;
        d.regs[`RI_HW_STAT] = hw_status_in;
        d.regs[`RI_SCAN] = scan_time_in;
        // Device drops the reset request; a host write in the same cycle wins
        if (err_reset_done_in) begin
            d.regs[`RI_ERR_RST] = q.regs[`RI_ERR_RST] & ~`FLAG_MASK;
        end
        if (hwr) begin
            d.regs[idx] = link.req_wdata;
        end
        for (int c = 0; c < 4; c++) begin
            req_bits = q.regs[REQ_IX[c]] & MASK[c];
            case (q.st[c])
                CH_IDLE: begin
                    // New transfer only with a request bit set and the ack word back at zero
                    if (req_bits != '0 && q.regs[ACK_IX[c]] == '0) begin
                        d.st[c] = CH_BUSY;
                        d.kind[c] = req_bits[1:0];
                    end
                end
                CH_BUSY: begin
                    if (chan_done_in[c]) begin
                        d.st[c] = CH_ACK;
                        d.regs[ACK_IX[c]] = {14'h0000, q.kind[c]};
                        if (c == `CHAN_BLK_RD && rd_err_in) begin
                            d.regs[ACK_IX[c]] = {14'h0000, q.kind[c]} | `ERR_FLAG;
                            d.regs[`RI_FB_ERR] = rd_err_code_in;
                        end
                    end
                end
                CH_ACK: begin
                    if (req_bits == '0) begin
                        d.st[c] = CH_IDLE;
                        d.regs[ACK_IX[c]] = '0;
                    end
                end
                default: begin
                    d.st[c] = CH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            q <= '{regs: '0, st: '{4{CH_IDLE}}, kind: '0, cpu_rdata: '0};
        end else begin
            q <= d;
        end
    end

    // Control CPU write comes last, so it wins an address collision
    always_ff @(posedge clk_in) begin
        if (ram_wr) begin
            ram[link.req_addr[`AW-1:1]] <= link.req_wdata;
        end
        if (cpu_we_in) begin
            ram[cpu_addr_in] <= cpu_wdata_in;
        end
    end

    always_comb begin
        for (int c = 0; c < 4; c++) begin
            chan_req_out[c] = (q.st[c] == CH_BUSY);
        end
    end

    assign cpu_rdata_out = q.cpu_rdata;
    assign rd_kind_out = q.kind[2];
    assign wr_kind_out = q.kind[3];
    assign rd_num_out = q.regs[`RI_RD_NUM];
    assign rd_off_out = q.regs[`RI_RD_OFF];
    assign rd_cnt_out = q.regs[`RI_RD_CNT];
    assign wr_num_out = q.regs[`RI_WR_NUM];
    assign wr_off_out = q.regs[`RI_WR_OFF];
    assign wr_cnt_out = q.regs[`RI_WR_CNT];
    assign card_out_reading_out = q.regs[`RI_CO_READ][0];
    assign card_in_present_out = q.regs[`RI_CI_PRES][0];
    assign special_out = q.regs[`RI_SPECIAL];
    assign err_reset_req_out = q.regs[`RI_ERR_RST][0];
endmodule

// [core/mailbox_host.sv]
/*
 Host end of the mailbox: raw word access plus a four-phase transfer sequencer.
 Assumes the device end on the mailbox_if link, same clock.
*/
`timescale 1ns/10ps

module mailbox_host
    import mailbox_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Link to device end
    mailbox_if.host link,
    // Raw word access, only while no transfer runs
    input wire logic acc_valid_in,
    output logic acc_ready_out,
    input wire logic acc_we_in,
    input wire logic [12:0] acc_addr_in,
    input wire logic [15:0] acc_wdata_in,
    output logic acc_rvalid_out,
    input wire logic acc_rready_in,
    output logic [15:0] acc_rdata_out,
    // Transfer sequencer
    input wire logic op_start_in,
    input wire logic [1:0] op_chan_in,
    input wire logic [1:0] op_kind_in,
    input wire logic [15:0] op_num_in,
    input wire logic [15:0] op_off_in,
    input wire logic [15:0] op_cnt_in,
    output logic op_busy_out,
    output logic op_acked_out,
    output logic [15:0] op_ack_word_out,
    input wire logic op_release_in,
    output logic op_done_out
);
    localparam addr_t [3:0] REQ_A = {`OFS_WR_REQ, `OFS_RD_REQ, `OFS_OUT_REQ, `OFS_IN_REQ};
    localparam addr_t [3:0] ACK_A = {`OFS_WR_ACK, `OFS_RD_ACK, `OFS_OUT_ACK, `OFS_IN_ACK};

    host_state_s_t q, d;
    logic raw, got, s_valid, s_we, raw_acc, raw_rsp;
    addr_t s_addr;
    word_t s_wdata, mask;

    assign raw = (q.st == H_IDLE);
    assign got = q.issued && link.rsp_valid;
    assign mask = q.chan[1] ? `BLK_MASK : `FLAG_MASK;
    assign raw_acc = raw && acc_valid_in && link.req_ready;
    assign raw_rsp = raw && link.rsp_valid && acc_rready_in;

    always_comb begin
        d = q;
        d.done = 1'b0;
        s_valid = 1'b0;
        s_we = 1'b1;
        s_addr = REQ_A[q.chan];
        s_wdata = '0;
        if (got) begin
            d.issued = 1'b0;
        end
        case (q.st)
            H_IDLE: begin
                // Starting waits until raw responses have drained
                if (op_start_in && !acc_valid_in && q.pend == 2'h0) begin
                    d.chan = op_chan_in;
                    d.kind = op_chan_in[1] ? op_kind_in : 2'h1;
                    d.prm = {op_cnt_in, op_off_in, op_num_in};
                    d.p = 2'h0;
                    d.st = op_chan_in[1] ? H_PARAM : H_REQ;
                end
            end
            H_PARAM: begin
                s_valid = !q.issued;
                s_addr = (q.chan[0] ? `OFS_WR_NUM : `OFS_RD_NUM) + addr_t'({q.p, 1'b0});
                s_wdata = q.prm[q.p];
                if (got) begin
                    d.p = q.p + 2'h1;
                    d.st = (q.p == 2'h2) ? H_REQ : H_PARAM;
                end
            end
            H_REQ: begin
                s_valid = !q.issued;
                s_wdata = {14'h0000, q.kind};
                if (got) begin
                    d.st = H_POLL;
                end
            end
            H_POLL: begin
                s_valid = !q.issued;
                s_we = 1'b0;
                s_addr = ACK_A[q.chan];
                if (got && (link.rsp_data & mask) != '0) begin
                    d.ack = link.rsp_data;
                    d.st = H_HOLD;
                end
            end
            H_HOLD: begin
                // User reads the data over raw-free window, then releases
                if (op_release_in) begin
                    d.st = H_CLR;
                end
            end
            H_CLR: begin
                s_valid = !q.issued;
                if (got) begin
                    d.st = H_POLLZ;
                end
            end
            H_POLLZ: begin
                s_valid = !q.issued;
                s_we = 1'b0;
                s_addr = ACK_A[q.chan];
                if (got && (link.rsp_data & mask) == '0) begin
                    d.st = H_IDLE;
                    d.done = 1'b1;
                end
            end
            default: begin
                d.st = H_IDLE;
            end
        endcase
        if (s_valid && link.req_ready) begin
            d.issued = 1'b1;
        end
        case ({raw_acc, raw_rsp})
            2'b10: d.pend = q.pend + 2'h1;
            2'b01: d.pend = q.pend - 2'h1;
            default: d.pend = q.pend;
        endcase
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            q <= '{st: H_IDLE, chan: '0, kind: '0, prm: '0, p: '0, issued: 1'b0,
                   pend: '0, ack: '0, done: 1'b0};
        end else begin
            q <= d;
        end
    end

    // Idle host passes raw accesses to any word; the sequencer drives only request, parameter and ack words
    assign link.req_valid = raw ? acc_valid_in : s_valid;
    assign link.req_we = raw ? acc_we_in : s_we;
    assign link.req_addr = raw ? acc_addr_in : s_addr;
    assign link.req_wdata = raw ? acc_wdata_in : s_wdata;
    assign link.rsp_ready = raw ? acc_rready_in : 1'b1;
    assign acc_ready_out = raw && link.req_ready;
    assign acc_rvalid_out = raw && link.rsp_valid;
    assign acc_rdata_out = link.rsp_data;
    assign op_busy_out = !raw;
    assign op_acked_out = (q.st == H_HOLD);
    assign op_ack_word_out = q.ack;
    assign op_done_out = q.done;
endmodule

// [verif/mailbox_properties.sv]
/*
 Checker for the word link between the two mailbox ends.
 Assumes one clock, async active-high reset, instantiated beside the link.
*/
`timescale 1ns/10ps

module mailbox_properties (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Link signals
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_we,
    input wire logic [12:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [15:0] rsp_data
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    logic [2:0] pend_q;

    // Outstanding answers; the buffer must never hold more than two
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pend_q <= 3'h0;
        end else begin
            pend_q <= pend_q + 3'(req_valid && req_ready) - 3'(rsp_valid && rsp_ready);
        end
    end

    chk_rsp_stands:
    assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
        else $error("response changed before taken");
    chk_req_held:
    assert property (req_valid && !req_ready |=> req_valid && $stable({req_we, req_addr, req_wdata}))
        else $error("request changed before taken");
    chk_rsp_prompt:
    assert property (req_valid && req_ready && !rsp_valid |=> rsp_valid)
        else $error("answer late");
    chk_rsp_quiet:
    assert property (!rsp_valid && !req_valid |=> !rsp_valid)
        else $error("answer without request");
    chk_full_stall:
    assert property (!req_ready |-> rsp_valid && pend_q == 3'h2)
        else $error("refused while not full");
    chk_drain_ready:
    assert property (rsp_valid && rsp_ready |=> req_ready)
        else $error("not ready after drain");
    chk_pend_match:
    assert property (rsp_valid == (pend_q != 3'h0))
        else $error("answer count mismatch");
    chk_pend_bound:
    assert property (pend_q <= 3'h2)
        else $error("too many answers pending");
endmodule

// [verif/dual_port_ram_mailbox_tb.sv]
/*
 Testbench joining host and device ends of the mailbox.
 Assumes the core files compiled first; drives the user sides only.
*/
`timescale 1ns/10ps

module dual_port_ram_mailbox_tb;
    import mailbox_pkg::*;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic av = 0, ardy, awe = 0, arv, arr = 1, st = 0, ack, done, rel = 0, cwe = 0, rerr = 0;
    logic erd = 0, erq;
    logic [1:0] cr;
    logic [12:0] aa = '0;
    logic [12:0] sa [4] = '{13'h1040, 13'h1042, 13'h104a, 13'h1060};
    logic [11:0] ca = '0;
    logic [1:0] oc = 0, ok = 0, rk;
    logic [3:0] creq, cdone = '0;
    word_t ad = '0, ard, on = '0, oo = '0, ocn = '0, ackw, rnum, crd, cd = '0, ecode = '0, q, v;
    word_t rcnt, spo;
    word_t sw [4];
    int bad_count = 0, compares = 0, seed = 32'h9a19157b, g, n;
    mailbox_if lk ();

    always #20 clk_in = ~clk_in;

    mailbox_device mailbox_device_i (.clk_in, .reset_in, .link(lk.device), .cpu_we_in(cwe),
        .cpu_addr_in(ca), .cpu_wdata_in(cd), .cpu_rdata_out(crd), .chan_req_out(creq),
        .rd_kind_out(rk), .wr_kind_out(), .chan_done_in(cdone), .rd_err_in(rerr),
        .rd_err_code_in(ecode), .rd_num_out(rnum), .rd_off_out(), .rd_cnt_out(rcnt),
        .wr_num_out(), .wr_off_out(), .wr_cnt_out(), .card_out_ready_in(cr[0]),
        .card_in_taken_in(cr[1]), .card_out_reading_out(), .card_in_present_out(),
        .status_in(sw[0]), .stop_err_in(sw[1]), .hw_status_in(sw[2]), .scan_time_in(sw[3]),
        .special_out(spo), .err_reset_req_out(erq), .err_reset_done_in(erd));
    mailbox_host mailbox_host_i (.clk_in, .reset_in, .link(lk.host), .acc_valid_in(av),
        .acc_ready_out(ardy), .acc_we_in(awe), .acc_addr_in(aa), .acc_wdata_in(ad),
        .acc_rvalid_out(arv), .acc_rready_in(arr), .acc_rdata_out(ard), .op_start_in(st),
        .op_chan_in(oc), .op_kind_in(ok), .op_num_in(on), .op_off_in(oo), .op_cnt_in(ocn),
        .op_busy_out(), .op_acked_out(ack), .op_ack_word_out(ackw), .op_release_in(rel),
        .op_done_out(done));
    mailbox_properties mailbox_properties_i (.clk_in, .reset_in, .req_valid(lk.req_valid),
        .req_ready(lk.req_ready), .req_we(lk.req_we), .req_addr(lk.req_addr),
        .req_wdata(lk.req_wdata), .rsp_valid(lk.rsp_valid), .rsp_ready(lk.rsp_ready),
        .rsp_data(lk.rsp_data));

    task check(input string nm, input word_t got, input word_t exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task tick;
        @(posedge clk_in);
        #1;
    endtask

    // One raw word access, answer left in q
    task acc(input logic we, input logic [12:0] a, input word_t d);
        awe = we;
        aa = a;
        ad = d;
        av = 1'b1;
        for (g = 0; g < 50 && !ardy; g++) tick();
        tick();
        av = 1'b0;
        for (g = 0; g < 50 && !arv; g++) tick();
        q = ard;
        tick();
    endtask

    function automatic word_t exp_ack(input logic [1:0] c, input logic [1:0] k, input logic e);
        exp_ack = (c < 2'h2) ? 16'h0001 : {e && c == 2'h2, 13'h0000, k};
    endfunction

    // Full four-phase transfer; control CPU side answered by the bench
    task op(input logic [1:0] c, input logic [1:0] k, input logic e);
        oc = c;
        ok = k;
        on = 16'($random(seed));
        oo = 16'($random(seed));
        ocn = 16'($random(seed));
        st = 1'b1;
        tick();
        st = 1'b0;
        for (g = 0; g < 80 && !creq[c]; g++) tick();
        rerr = e;
        ecode = 16'($random(seed));
        cdone[c] = 1'b1;
        tick();
        cdone = 4'h0;
        for (g = 0; g < 80 && !ack; g++) tick();
        check("ack word", ackw, exp_ack(c, k, e));
        check("request line", {15'h0, creq[c]}, 16'h0);
        if (c == 2'h2) check("read kind", {14'h0, rk}, {14'h0, k});
        if (c == 2'h2) check("read number", rnum, on);
        if (c == 2'h2) check("read count", rcnt, ocn);
        rel = 1'b1;
        tick();
        rel = 1'b0;
        for (g = 0; g < 80 && !done; g++) tick();
        check("done", {15'h0, done}, 16'h1);
    endtask

    task complete_run;
        $display("Checks %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        for (n = 0; n < 4; n++) sw[n] = 16'($random(seed));
        cr = 2'($random(seed));
        repeat (8) @(posedge clk_in);
        #1 reset_in = 1'b0;
        tick();
        for (n = 0; n < 4; n++) begin
            acc(1'b0, sa[n], 16'h0);
            check("status word", q, sw[n]);
        end
        acc(1'b0, 13'h1034, 16'h0);
        check("card ready", q, {15'h0000, cr[0]});
        acc(1'b0, 13'h103a, 16'h0);
        check("card taken", q, {15'h0000, cr[1]});
        for (n = 0; n < 3; n++) begin
            v = 16'($random(seed));
            acc(1'b1, 13'h1020 + 13'(2 * n), v);
            acc(1'b0, 13'h1020 + 13'(2 * n), 16'h0);
            check("block parameter", q, v);
        end
        acc(1'b1, 13'h1012, 16'hffff);
        acc(1'b0, 13'h1012, 16'h0);
        check("owned ack word", q, 16'h0);
        v = 16'($random(seed));
        acc(1'b1, 13'h0600, v);
        ca = 12'h300;
        tick();
        check("cpu view", crd, v);
        cwe = 1'b1;
        ca = 12'h380;
        cd = 16'h5a5a;
        tick();
        cwe = 1'b0;
        acc(1'b1, 13'h0700, 16'ha5a5);
        acc(1'b0, 13'h0700, 16'h0);
        check("read range", q, 16'h5a5a);
        acc(1'b1, 13'h1300, v);
        acc(1'b0, 13'h1300, 16'h0);
        check("fast area", q, v);
        acc(1'b1, 13'h1044, v);
        check("special word", spo, v);
        acc(1'b1, 13'h1046, 16'h0001);
        check("reset request", {15'h0000, erq}, 16'h0001);
        erd = 1'b1;
        tick();
        erd = 1'b0;
        check("reset cleared", {15'h0000, erq}, 16'h0000);
        $display("map tests done");
        // Stalled receiver: exactly two words fit
        arr = 1'b0;
        awe = 1'b1;
        aa = 13'h0602;
        av = 1'b1;
        n = 0;
        for (g = 0; g < 4; g++) begin
            if (ardy) n++;
            tick();
        end
        // Third request stays up until the drain lets it in
        check("buffered", 16'(n), 16'h2);
        arr = 1'b1;
        n = 0;
        for (g = 0; g < 6; g++) begin
            if (arv) n++;
            if (ardy) begin
                tick();
                av = 1'b0;
            end else begin
                tick();
            end
        end
        check("drained", 16'(n), 16'h3);
        $display("buffer test done");
        for (n = 0; n < 4; n++) op(2'(n), 2'h1, 1'b0);
        op(2'h2, 2'h2, 1'b0);
        op(2'h3, 2'h3, 1'b0);
        op(2'h2, 2'h1, 1'b1);
        acc(1'b0, 13'h1048, 16'h0);
        check("error code", q, ecode);
        $display("transfer tests done");
        complete_run();
    end

    initial begin
        #2000000;
        bad_count++;
        complete_run();
    end
endmodule
